/* File: mcv_consts.svh */
// constant header for the static configuration vector decoder
//
// Overview of operation
// - all 80 vector bits captured at power-up and on every MAC reset.
// - bit 67: vector presets registers; software may read or rewrite.
// - bits 73 and 70:64 change only after the next MAC reset.
// - bits 78:74 act only in SGMII or 1000BASE-X modes.
// - isolate bit blocks frames both ways through the sublayer.
// - bit 75 low power persists until reset; bit 74 serial loopback.
// - bit 73 enables the management data interface.
// - bits 72:71 pick speed: 10=1000, 01=100, 00=10, 11 not applicable.
// - bits 70:68: at most one set; all clear gives MII/GMII.
// - bits 66/65 widen transmit/receive client paths to 16 bits.
// - bit 64 enables address filter; bit 63 disables length/type check.
// - bit 62 with full duplex: received pause inhibits transmitter.
// - bit 61 with full duplex: pause request sends flow control frame.
// - bit 60 holds transmitter in reset; bit 53 holds receiver in reset.
// - bit 59 transmit jumbo, bit 52 receive jumbo.
// - bit 58 client supplies FCS; bit 51 forwards received FCS.
// - receiver checks FCS whether forwarded or stripped.
// - bit 57 enables transmitter, bit 50 enables receiver.
// - bits 56/49 VLAN enables; bits 55/48 half duplex when set.
// - bit 54 uses client gap delay; clear inserts at least minimum gap.
// - bits 47:0 pause station address, low byte first on the wire.
// - MAC held in reset until clock manager lock is high.
`ifndef MCV_CONSTS_SVH
`define MCV_CONSTS_SVH

`define MCV_VEC_W 80
`define MCV_RESET_VEC 80'h8000_0000_0000_0000_0000
`define MCV_SUB_RESET 78
`define MCV_SUB_AN 77
`define MCV_SUB_ISO 76
`define MCV_SUB_LP 75
`define MCV_SUB_LB 74
`define MCV_MDIO_EN 73
`define MCV_SPEED_HI 72
`define MCV_SPEED_LO 71
`define MCV_RGMII 70
`define MCV_SGMII 69
`define MCV_BASEX 68
`define MCV_HOST_EN 67
`define MCV_TX16 66
`define MCV_RX16 65
`define MCV_ADDR_FILT 64
`define MCV_LT_DIS 63
`define MCV_RX_FC 62
`define MCV_TX_FC 61
`define MCV_TX_RST 60
`define MCV_TX_JUMBO 59
`define MCV_TX_FCS 58
`define MCV_TX_EN 57
`define MCV_TX_VLAN 56
`define MCV_TX_HD 55
`define MCV_TX_IFG 54
`define MCV_RX_RST 53
`define MCV_RX_JUMBO 52
`define MCV_RX_FCS 51
`define MCV_RX_EN 50
`define MCV_RX_VLAN 49
`define MCV_RX_HD 48
`define MCV_ADDR_HI 47
`define MCV_MIN_IFG 8'h0c

// register port
`define MCV_ADDR_W 4
`define MCV_REG_PHY 4'h0
`define MCV_REG_MODE 4'h1
`define MCV_REG_MAC 4'h2
`define MCV_REG_ADDR_LO 4'h3
`define MCV_REG_ADDR_HI 4'h4
`define MCV_REG_STATUS 4'h5

`endif

/* File: mcv_pkg.sv */
// types for the static configuration vector decoder
package mcv_pkg;
  typedef enum logic [1:0]
  {
    MCV_SPD_10 = 2'h0,
    MCV_SPD_100 = 2'h1,
    MCV_SPD_1000 = 2'h2,
    MCV_SPD_NA = 2'h3
  } mcv_speed_t;

  typedef enum logic [1:0]
  {
    MCV_IF_MII_GMII = 2'h0,
    MCV_IF_RGMII = 2'h1,
    MCV_IF_SGMII = 2'h3,
    MCV_IF_BASEX = 2'h2
  } mcv_phy_if_t;

  typedef enum logic [1:0]
  {
    MCV_ST_RESET = 2'h0,
    MCV_ST_LOAD = 2'h1,
    MCV_ST_RUN = 2'h3
  } mcv_state_t;

  typedef struct packed {
    logic sub_reset;
    logic sub_autoneg_enable;
    logic sub_isolate;
    logic transceiver_low_power;
    logic transceiver_serial_loopback;
  } mcv_phy_cfg_t;

  typedef struct packed {
    logic mdio_enable;
    mcv_speed_t speed;
    mcv_phy_if_t phy_if;
    logic host_enable;
    logic tx_wide;
    logic rx_wide;
  } mcv_mode_cfg_t;

  typedef struct packed {
    logic addr_filter_enable;
    logic len_type_check_disable;
    logic rx_flow_enable;
    logic tx_flow_enable;
    logic tx_reset;
    logic tx_jumbo;
    logic tx_inband_fcs;
    logic tx_enable;
    logic tx_vlan;
    logic tx_half_duplex;
    logic tx_ifg_adjust;
    logic rx_reset;
    logic rx_jumbo;
    logic rx_inband_fcs;
    logic rx_enable;
    logic rx_vlan;
    logic rx_half_duplex;
    logic [47:0] pause_address;
  } mcv_mac_cfg_t;
endpackage

/* File: mcv_decode.sv */
// static configuration vector capture, hold and decode
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "mcv_consts.svh"

module mcv_decode
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clock_manager_lock_in,
  input wire logic [79:0] static_config_vector_in,
  input wire logic client_pause_request_in,
  input wire logic [7:0] client_gap_delay_in,
  input wire logic rx_pause_frame_in,
  input wire logic [`MCV_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic mac_reset_out,
  output logic loaded_out,
  output mcv_pkg::mcv_phy_cfg_t phy_cfg_out,
  output mcv_pkg::mcv_mode_cfg_t mode_cfg_out,
  output mcv_pkg::mcv_mac_cfg_t mac_cfg_out,
  output logic mdio_enable_out,
  output logic tx_engine_reset_out,
  output logic rx_engine_reset_out,
  output logic tx_engine_run_out,
  output logic rx_engine_run_out,
  output logic sublayer_block_tx_out,
  output logic sublayer_block_rx_out,
  output logic tx_inhibit_out,
  output logic send_pause_out,
  output logic [7:0] tx_gap_out,
  output logic rx_fcs_check_out,
  output logic rx_fcs_strip_out,
  output logic mode_conflict_out
);

  // ****************************************
  // capture state
  // ****************************************
  mcv_pkg::mcv_state_t state;
  mcv_pkg::mcv_state_t next_state;
  logic [79:0] captured;
  logic [79:0] shadow;
  logic lp_latch;
  logic [79:0] live;
  logic host_mode;
  logic serdes_mode;

  // lock low keeps the mac in reset, like a held reset
  always_comb
  begin
    next_state = state;
    case (state)
      mcv_pkg::MCV_ST_RESET:
        if (clock_manager_lock_in)
          next_state = mcv_pkg::MCV_ST_LOAD;
      mcv_pkg::MCV_ST_LOAD:
        if (clock_manager_lock_in)
          next_state = mcv_pkg::MCV_ST_RUN;
        else
          next_state = mcv_pkg::MCV_ST_RESET;
      mcv_pkg::MCV_ST_RUN:
        if (!clock_manager_lock_in)
          next_state = mcv_pkg::MCV_ST_RESET;
      default:
        next_state = mcv_pkg::MCV_ST_RESET;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      state <= mcv_pkg::MCV_ST_RESET;
    else
      state <= next_state;
  end

  // whole vector taken on leaving reset
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      captured <= `MCV_RESET_VEC;
    else if (state == mcv_pkg::MCV_ST_LOAD)
      captured <= static_config_vector_in;
  end

  assign host_mode = captured[`MCV_HOST_EN];

  // ****************************************
  // software-writable copy (host mode)
  // ****************************************
  // of the mode group only bit 64 is written here (MAC register), and live ignores it: it only moves at the next reset
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      shadow <= `MCV_RESET_VEC;
    else if (state == mcv_pkg::MCV_ST_LOAD)
      shadow <= static_config_vector_in;
    else if (reg_wr_in && host_mode && state == mcv_pkg::MCV_ST_RUN)
    begin
      if (reg_addr_in == `MCV_REG_PHY)
        shadow[78:74] <= reg_wdata_in[4:0];
      else if (reg_addr_in == `MCV_REG_MODE)
        shadow[72:71] <= reg_wdata_in[6:5];
      else if (reg_addr_in == `MCV_REG_MAC)
        shadow[64:48] <= reg_wdata_in[16:0];
      else if (reg_addr_in == `MCV_REG_ADDR_LO)
        shadow[31:0] <= reg_wdata_in;
      else if (reg_addr_in == `MCV_REG_ADDR_HI)
        shadow[47:32] <= reg_wdata_in[15:0];
    end
  end

  // host off: the pins act directly, apart from the reset-only mode group
  always_comb
  begin
    if (host_mode)
      live = shadow;
    else
      live = static_config_vector_in;
    live[73] = captured[73];
    live[70:64] = captured[70:64];
    live[79] = captured[79];
  end

  // low power sticks until the next reset
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      lp_latch <= 1'b0;
    else if (state != mcv_pkg::MCV_ST_RUN)
      lp_latch <= 1'b0;
    else if (live[`MCV_SUB_LP] && serdes_mode)
      lp_latch <= 1'b1;
  end

  // ****************************************
  // decode
  // ****************************************
  logic full_duplex_tx;
  logic full_duplex_rx;
  mcv_pkg::mcv_phy_if_t phy_if;

  always_comb
  begin
    if (live[`MCV_RGMII])
      phy_if = mcv_pkg::MCV_IF_RGMII;
    else if (live[`MCV_SGMII])
      phy_if = mcv_pkg::MCV_IF_SGMII;
    else if (live[`MCV_BASEX])
      phy_if = mcv_pkg::MCV_IF_BASEX;
    else
      phy_if = mcv_pkg::MCV_IF_MII_GMII;
  end

  assign serdes_mode = live[`MCV_SGMII] | live[`MCV_BASEX];
  assign full_duplex_tx = ~live[`MCV_TX_HD];
  assign full_duplex_rx = ~live[`MCV_RX_HD];

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phy_cfg_out <= '0;
      mode_cfg_out <= '0;
      mac_cfg_out <= '0;
      mdio_enable_out <= 1'b0;
      mode_conflict_out <= 1'b0;
    end
    else
    begin
      phy_cfg_out.sub_reset <=
        serdes_mode & live[`MCV_SUB_RESET];
      phy_cfg_out.sub_autoneg_enable <= serdes_mode & live[`MCV_SUB_AN];
      phy_cfg_out.sub_isolate <= serdes_mode & live[`MCV_SUB_ISO];
      phy_cfg_out.transceiver_low_power <= lp_latch;
      phy_cfg_out.transceiver_serial_loopback <=
        serdes_mode & live[`MCV_SUB_LB];
      mode_cfg_out.mdio_enable <= live[`MCV_MDIO_EN];
      mode_cfg_out.speed <=
        mcv_pkg::mcv_speed_t'(live[72:71]);
      mode_cfg_out.phy_if <= phy_if;
      mode_cfg_out.host_enable <= live[`MCV_HOST_EN];
      mode_cfg_out.tx_wide <= live[`MCV_TX16];
      mode_cfg_out.rx_wide <= live[`MCV_RX16];
      mac_cfg_out <=
        mcv_pkg::mcv_mac_cfg_t'(live[64:0]);
      mdio_enable_out <= live[`MCV_MDIO_EN];
      mode_conflict_out <= (live[70] & live[69]) | (live[70] & live[68])
        | (live[69] & live[68]);
    end
  end

  // ****************************************
  // engine controls
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_engine_reset_out <= 1'b1;
      rx_engine_reset_out <= 1'b1;
      tx_engine_run_out <= 1'b0;
      rx_engine_run_out <= 1'b0;
      sublayer_block_tx_out <= 1'b0;
      sublayer_block_rx_out <= 1'b0;
      tx_inhibit_out <= 1'b0;
      send_pause_out <= 1'b0;
      tx_gap_out <= `MCV_MIN_IFG;
      rx_fcs_strip_out <= 1'b1;
    end
    else
    begin
      tx_engine_reset_out <= mac_reset_out | live[`MCV_TX_RST];
      rx_engine_reset_out <= mac_reset_out | live[`MCV_RX_RST];
      tx_engine_run_out <= ~mac_reset_out & live[`MCV_TX_EN]
        & ~live[`MCV_TX_RST];
      rx_engine_run_out <= ~mac_reset_out & live[`MCV_RX_EN]
        & ~live[`MCV_RX_RST];
      sublayer_block_tx_out <= serdes_mode & live[`MCV_SUB_ISO];
      sublayer_block_rx_out <= serdes_mode & live[`MCV_SUB_ISO];
      tx_inhibit_out <= rx_pause_frame_in & live[`MCV_RX_FC]
        & full_duplex_rx;
      send_pause_out <= client_pause_request_in & live[`MCV_TX_FC]
        & full_duplex_tx;
      if (live[`MCV_TX_IFG])
        tx_gap_out <= client_gap_delay_in;
      else
        tx_gap_out <= `MCV_MIN_IFG;
      rx_fcs_strip_out <= ~live[`MCV_RX_FCS];
    end
  end

  // checking never depends on forwarding
  assign rx_fcs_check_out = 1'b1;
  assign mac_reset_out = (state != mcv_pkg::MCV_ST_RUN);
  assign loaded_out = (state == mcv_pkg::MCV_ST_RUN);

  // ****************************************
  // register read port
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
    begin
      if (reg_addr_in == `MCV_REG_PHY)
        reg_rdata_out <= {27'h0, live[78:74]};
      else if (reg_addr_in == `MCV_REG_MODE)
        reg_rdata_out <= {24'h0, live[73:66]};
      else if (reg_addr_in == `MCV_REG_MAC)
        reg_rdata_out <= {15'h0, live[64:48]};
      else if (reg_addr_in == `MCV_REG_ADDR_LO)
        reg_rdata_out <= live[31:0];
      else if (reg_addr_in == `MCV_REG_ADDR_HI)
        reg_rdata_out <= {16'h0, live[47:32]};
      else if (reg_addr_in == `MCV_REG_STATUS)
        reg_rdata_out <= {28'h0, mode_conflict_out, lp_latch,
          host_mode, loaded_out};
      else
        reg_rdata_out <= 32'h0000_0000;
    end
    else
      reg_rdata_out <= 32'h0000_0000;
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_capture;
    @(posedge clk_in) disable iff (rst_in)
    state == mcv_pkg::MCV_ST_LOAD |=>
      captured == $past(static_config_vector_in);
  endproperty
  a_capture: assert property (p_capture)
    else $error("vector not captured on load");

  property p_lock_hold;
    @(posedge clk_in) disable iff (rst_in)
    !clock_manager_lock_in |=> mac_reset_out;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("mac left reset without lock");

  property p_mode_frozen;
    @(posedge clk_in) disable iff (rst_in)
    state == mcv_pkg::MCV_ST_RUN && $past(state) == mcv_pkg::MCV_ST_RUN
      |-> $stable(live[70:64]) && $stable(live[73]);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen)
    else $error("mode group changed without reset");

  property p_isolate;
    @(posedge clk_in) disable iff (rst_in)
    serdes_mode && live[`MCV_SUB_ISO] |=>
      sublayer_block_tx_out && sublayer_block_rx_out;
  endproperty
  a_isolate: assert property (p_isolate)
    else $error("isolate did not block frames");

  property p_low_power;
    @(posedge clk_in) disable iff (rst_in)
    lp_latch && state == mcv_pkg::MCV_ST_RUN |=> lp_latch;
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("low power cleared without reset");

  property p_pause_ignored;
    @(posedge clk_in) disable iff (rst_in)
    !live[`MCV_TX_FC] |=> !send_pause_out;
  endproperty
  a_pause_ignored: assert property (p_pause_ignored)
    else $error("pause sent with flow control off");

  property p_gap;
    @(posedge clk_in) disable iff (rst_in)
    !live[`MCV_TX_IFG] |=> tx_gap_out == `MCV_MIN_IFG;
  endproperty
  a_gap: assert property (p_gap)
    else $error("gap not at minimum");

  property p_tx_reset;
    @(posedge clk_in) disable iff (rst_in)
    live[`MCV_TX_RST] |=> tx_engine_reset_out && !tx_engine_run_out;
  endproperty
  a_tx_reset: assert property (p_tx_reset)
    else $error("transmitter not held in reset");

  property p_rx_reset;
    @(posedge clk_in) disable iff (rst_in)
    live[`MCV_RX_RST] |=> rx_engine_reset_out && !rx_engine_run_out;
  endproperty
  a_rx_reset: assert property (p_rx_reset)
    else $error("receiver not held in reset");

  property p_phy_gated;
    @(posedge clk_in) disable iff (rst_in)
    !serdes_mode |=> !phy_cfg_out.sub_reset && !phy_cfg_out.sub_isolate
      && !phy_cfg_out.sub_autoneg_enable
      && !phy_cfg_out.transceiver_serial_loopback;
  endproperty
  a_phy_gated: assert property (p_phy_gated)
    else $error("sublayer control active outside serdes mode");

  property p_one_if;
    @(posedge clk_in) disable iff (rst_in)
    $onehot0(live[70:68]) |=> !mode_conflict_out;
  endproperty
  a_one_if: assert property (p_one_if)
    else $error("interface conflict flagged without a clash");

  property p_tx_disable;
    @(posedge clk_in) disable iff (rst_in)
    !live[`MCV_TX_EN] |=> !tx_engine_run_out;
  endproperty
  a_tx_disable: assert property (p_tx_disable)
    else $error("transmitter runs while disabled");

  property p_rx_disable;
    @(posedge clk_in) disable iff (rst_in)
    !live[`MCV_RX_EN] |=> !rx_engine_run_out;
  endproperty
  a_rx_disable: assert property (p_rx_disable)
    else $error("receiver runs while disabled");

  property p_rx_fc_off;
    @(posedge clk_in) disable iff (rst_in)
    !live[`MCV_RX_FC] |=> !tx_inhibit_out;
  endproperty
  a_rx_fc_off: assert property (p_rx_fc_off)
    else $error("transmitter inhibited with flow control off");

  property p_lock_engines;
    @(posedge clk_in) disable iff (rst_in)
    mac_reset_out |=> tx_engine_reset_out && rx_engine_reset_out;
  endproperty
  a_lock_engines: assert property (p_lock_engines)
    else $error("engines left reset while mac held");

endmodule

/* File: mcv_fabric_model.sv */
// fabric tie-off model feeding the static configuration vector
`timescale 1ns/1ps
// ********
// tie-off driver
// ********
module mcv_fabric_model
(
  input wire logic clk_in,
  input wire logic [79:0] setting_in,
  output logic [79:0] static_config_vector_out
);
  // ties only move on a clock edge, so the decoder never sees a half change
  always_ff @(posedge clk_in)
  begin
    static_config_vector_out <= {1'b1, setting_in[78:0]};
    // a clashing interface request is dropped rather than passed on
    if (!$onehot0(setting_in[70:68]))
      static_config_vector_out[70:68] <= 3'h0;
  end
endmodule

/* File: mcv_decode_tb.sv */
// self-checking bench for the static configuration vector decoder
`timescale 1ns/1ps
`include "mcv_consts.svh"
module mcv_decode_tb;
  // ********
  // signals
  // ********
  localparam logic [79:0] BASE = 80'hff00_0204_0605_0403_0201;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic lock = 1'b1;
  logic [79:0] setting = BASE;
  logic [79:0] vec;
  logic pause_req = 1'b0;
  logic [7:0] gap = 8'h00;
  logic rx_pause = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic mac_rst, loaded, mdio_en, tx_rst, tx_run, blk_tx, blk_rx;
  logic inhibit, send_pause, fcs_chk, fcs_strip;
  logic rx_rst, rx_run, conflict;
  logic [7:0] tx_gap;
  mcv_pkg::mcv_phy_cfg_t phy;
  mcv_pkg::mcv_mode_cfg_t mode;
  mcv_pkg::mcv_mac_cfg_t mac;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] d;

  mcv_fabric_model mcv_fabric_model_inst
  (
    .clk_in(clk_in),
    .setting_in(setting),
    .static_config_vector_out(vec)
  );

  mcv_decode mcv_decode_inst
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clock_manager_lock_in(lock),
    .static_config_vector_in(vec),
    .client_pause_request_in(pause_req),
    .client_gap_delay_in(gap),
    .rx_pause_frame_in(rx_pause),
    .reg_addr_in(addr),
    .reg_wdata_in(wdata),
    .reg_wr_in(wr),
    .reg_rd_in(rd),
    .reg_rdata_out(rdata),
    .mac_reset_out(mac_rst),
    .loaded_out(loaded),
    .phy_cfg_out(phy),
    .mode_cfg_out(mode),
    .mac_cfg_out(mac),
    .mdio_enable_out(mdio_en),
    .tx_engine_reset_out(tx_rst),
    .rx_engine_reset_out(rx_rst),
    .tx_engine_run_out(tx_run),
    .rx_engine_run_out(rx_run),
    .sublayer_block_tx_out(blk_tx),
    .sublayer_block_rx_out(blk_rx),
    .tx_inhibit_out(inhibit),
    .send_pause_out(send_pause),
    .tx_gap_out(tx_gap),
    .rx_fcs_check_out(fcs_chk),
    .rx_fcs_strip_out(fcs_strip),
    .mode_conflict_out(conflict)
  );

  initial
  begin
    forever #25 clk_in = ~clk_in;
  end

  // about 150 cycles are needed; anything far beyond means a hang
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  // ********
  // shared tasks
  // ********
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic fin(input string n);
    $display("test %s done", n);
  endtask

  task automatic drive(input logic [79:0] s);
    @(posedge clk_in);
    setting <= s;
  endtask

  task automatic do_reset();
    int n;
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    n = 0;
    while (loaded !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    tick(2);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_capture();
    do_reset();
    chk(loaded, 1'b1);
    chk(mode.speed, mcv_pkg::MCV_SPD_1000);
    chk(mode.phy_if, mcv_pkg::MCV_IF_MII_GMII);
    chk(mdio_en, 1'b1);
    chk(mac.pause_address, 48'h0605_0403_0201);
    chk(phy, 5'h00);
    chk(tx_gap, `MCV_MIN_IFG);
    wr_reg(`MCV_REG_MAC, 32'h0);
    tick(2);
    chk(tx_run, 1'b1);
    fin("capture");
  endtask

  task automatic t_freeze();
    logic [79:0] s;
    s = BASE;
    s[72:71] = 2'b01;
    s[73] = 1'b0;
    s[70] = 1'b1;
    s[57] = 1'b0;
    drive(s);
    tick(4);
    chk(mode.speed, mcv_pkg::MCV_SPD_100);
    chk(mode.phy_if, mcv_pkg::MCV_IF_MII_GMII);
    chk(mdio_en, 1'b1);
    chk(tx_run, 1'b0);
    do_reset();
    chk(mode.phy_if, mcv_pkg::MCV_IF_RGMII);
    chk(mdio_en, 1'b0);
    fin("freeze");
  endtask

  task automatic t_modes();
    logic [79:0] s;
    mcv_pkg::mcv_phy_if_t ife [3];
    ife = '{mcv_pkg::MCV_IF_BASEX, mcv_pkg::MCV_IF_SGMII,
      mcv_pkg::MCV_IF_RGMII};
    for (int i = 0; i < 3; i++)
    begin
      s = BASE;
      s[72:71] = i[1:0];
      s[70:68] = 3'h1 << i;
      drive(s);
      do_reset();
      chk(mode.speed, i);
      chk(mode.phy_if, ife[i]);
    end
    fin("modes");
  endtask

  task automatic t_serdes();
    logic [79:0] s;
    s = BASE;
    s[69] = 1'b1;
    drive(s);
    do_reset();
    chk(phy, 5'h1f);
    chk({blk_tx, blk_rx}, 2'h3);
    s[76:75] = 2'h0;
    drive(s);
    tick(4);
    chk({blk_tx, blk_rx}, 2'h0);
    chk(phy.transceiver_low_power, 1'b1);
    do_reset();
    chk(phy.transceiver_low_power, 1'b0);
    fin("serdes");
  endtask

  task automatic t_flow();
    logic [79:0] s;
    s = BASE;
    s[62:60] = 3'h7;
    s[54] = 1'b1;
    s[51] = 1'b1;
    drive(s);
    gap <= 8'h20;
    rx_pause <= 1'b1;
    pause_req <= 1'b1;
    tick(4);
    chk({inhibit, send_pause, tx_rst}, 3'h7);
    chk(tx_gap, 8'h20);
    chk({fcs_chk, fcs_strip}, 2'h2);
    s[55] = 1'b1;
    s[48] = 1'b1;
    s[60] = 1'b0;
    s[54] = 1'b0;
    s[51] = 1'b0;
    drive(s);
    tick(4);
    chk({inhibit, send_pause, tx_rst}, 3'h0);
    chk(tx_gap, `MCV_MIN_IFG);
    chk({fcs_chk, fcs_strip}, 2'h3);
    rx_pause <= 1'b0;
    pause_req <= 1'b0;
    fin("flow");
  endtask

  task automatic t_rx();
    logic [79:0] s;
    s = BASE;
    s[70:69] = 2'h3;
    s[66:65] = 2'h3;
    s[63] = 1'b1;
    s[59:58] = 2'h3;
    s[56] = 1'b1;
    s[53:52] = 2'h3;
    s[49] = 1'b1;
    drive(s);
    do_reset();
    chk({conflict, mode.phy_if}, 3'h0);
    chk({mode.tx_wide, mode.rx_wide}, 2'h3);
    chk(mac.len_type_check_disable, 1'b1);
    chk({mac.tx_jumbo, mac.rx_jumbo}, 2'h3);
    chk(mac.tx_inband_fcs, 1'b1);
    chk({mac.tx_vlan, mac.rx_vlan}, 2'h3);
    chk({rx_rst, rx_run}, 2'h2);
    s[53] = 1'b0;
    s[50] = 1'b0;
    drive(s);
    tick(4);
    chk({rx_rst, rx_run}, 2'h0);
    fin("rx");
  endtask

  task automatic t_host();
    logic [79:0] s;
    s = BASE;
    s[67] = 1'b1;
    drive(s);
    do_reset();
    rd_reg(`MCV_REG_STATUS, d);
    chk(d, 32'h3);
    rd_reg(`MCV_REG_ADDR_LO, d);
    chk(d, 32'h0403_0201);
    rd_reg(4'h9, d);
    chk(d, 32'h0);
    wr_reg(`MCV_REG_MAC, 32'h0001_0004);
    tick(2);
    chk({mac.addr_filter_enable, tx_run}, 2'h0);
    rd_reg(`MCV_REG_MAC, d);
    chk(d, 32'h0000_0004);
    wr_reg(`MCV_REG_MODE, 32'h0000_0020);
    tick(2);
    chk(mode.speed, mcv_pkg::MCV_SPD_100);
    rd_reg(`MCV_REG_MODE, d);
    chk(d, 32'h0000_00a2);
    fin("host");
  endtask

  task automatic t_lock();
    @(posedge clk_in);
    lock <= 1'b0;
    tick(3);
    chk({mac_rst, loaded}, 2'h2);
    @(posedge clk_in);
    lock <= 1'b1;
    tick(4);
    chk({mac_rst, loaded}, 2'h1);
    fin("lock");
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    t_capture();
    t_freeze();
    t_modes();
    t_serdes();
    t_flow();
    t_rx();
    t_host();
    t_lock();
    end_of_test();
  end
endmodule
